/* sim/ssp_far_end.sv */
// Remote synchronous serial party: shifts bits in and out, can clock a slave.
`timescale 1ns/1ps
module ssp_far_end (
    input wire ck_in,
    input wire dat_in,
    input wire dut_oe_in,
    output reg drv_out = 1'b0,
    output reg slv_ck_out = 1'b0
);
    reg [35:0] tx_bits = 36'h0;
    reg [35:0] rx_bits = 36'h0;
    integer tx_k = 0;
    integer rx_n = 0;
    integer n_edge = 0;
    task start(input [35:0] b);
        tx_bits = b;
        rx_bits = 36'h0;
        tx_k = 0;
        rx_n = 0;
        n_edge = 0;
    endtask
    // Unrelated phase to the system clock; the clock stands low between frames.
    task clocks(input integer n);
        #3;
        repeat (n)
        begin
            #40 slv_ck_out = 1'b1;
            #40 slv_ck_out = 1'b0;
        end
    endtask
    always @(posedge ck_in)
        drv_out <= tx_bits[tx_k];
    always @(negedge ck_in)
    begin
        n_edge <= n_edge + 1;
        tx_k <= tx_k + 1;
        if (dut_oe_in)
        begin
            rx_bits[rx_n] <= dat_in;
            rx_n <= rx_n + 1;
        end
    end
endmodule // ssp_far_end

/* sim/ssp_port_monitor.sv */
// Concurrent port checks for the synchronous serial port.
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_port_monitor (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire [`SSP_ADDR_W-1:0] addr_in,
    input wire [7:0] wr_data_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rd_data_out,
    input wire data_line_in,
    input wire data_line_out,
    input wire data_line_oe_out,
    input wire clock_line_in,
    input wire clock_line_out,
    input wire clock_line_oe_out,
    input wire rx_pending_out,
    input wire tx_ready_out
);
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire ctl_wr = wr_in && addr_in == `SSP_REG_RX_CTRL;
    wire tx_wr = wr_in && addr_in == `SSP_REG_TX_DATA;
    wire pop = rd_in && addr_in == `SSP_REG_RX_DATA;
    wire kill = pop || (ctl_wr && !wr_data_in[7]);
    reg arm;
    reg nine;
    reg [3:0] n_fall;
    // Counts master clocks since single receive was armed; saturates to stay meaningful.
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            arm <= 1'b0;
            nine <= 1'b0;
            n_fall <= 4'h0;
        end
        else if (ctl_wr)
        begin
            arm <= wr_data_in[5] && !wr_data_in[4];
            nine <= wr_data_in[6];
            n_fall <= 4'h0;
        end
        else
        begin
            if (tx_wr)
                arm <= 1'b0;
            if ($fell(clock_line_out) && n_fall != 4'hf)
                n_fall <= n_fall + 4'h1;
        end
    end
    sequence rx_on_s;
        ctl_wr && wr_data_in[5:4] != 2'b00;
    endsequence
    sequence flush_s;
        ctl_wr && !wr_data_in[7];
    endsequence
    sequence clk_high_s;
        clock_line_out [*3];
    endsequence
    rx_release_a: assert property (rx_on_s |-> ##[1:3] !data_line_oe_out)
        else $error("data line still driven in receive mode");
    slave_clock_a: assert property (wr_in && addr_in == `SSP_REG_TX_CTRL
        && !wr_data_in[7] |-> ##[1:3] !clock_line_oe_out)
        else $error("clock line still driven as slave");
    clock_drive_a: assert property ($changed(clock_line_out) |-> clock_line_oe_out)
        else $error("clock moved without driver enabled");
    data_stable_a: assert property (clk_high_s ##0 data_line_oe_out
        && $past(data_line_oe_out) |-> $stable(data_line_out))
        else $error("data changed away from leading edge");
    single_count_a: assert property (arm |-> n_fall <= (nine ? 4'h9 : 4'h8))
        else $error("too many clocks for one character");
    tx_busy_a: assert property (tx_wr |-> ##[1:3] !tx_ready_out)
        else $error("transmit ready not lowered by write");
    pend_fall_a: assert property ($fell(rx_pending_out)
        |-> $past(kill) || $past(kill, 2) || $past(kill, 3))
        else $error("pending dropped without read or flush");
    port_flush_a: assert property (flush_s |-> ##[1:4] !rx_pending_out)
        else $error("port disable did not flush");
    rd_zero_a: assert property (rd_data_out != 8'h00 |-> $past(rd_in))
        else $error("read data outside read cycle");
endmodule // ssp_port_monitor
bind ssp_port ssp_port_monitor i_mon (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .data_line_in(data_line_in),
    .data_line_out(data_line_out), .data_line_oe_out(data_line_oe_out),
    .clock_line_in(clock_line_in), .clock_line_out(clock_line_out),
    .clock_line_oe_out(clock_line_oe_out), .rx_pending_out(rx_pending_out),
    .tx_ready_out(tx_ready_out));

/* sim/tb_ssp_port.sv */
// Self-checking testbench for the synchronous serial port.
`timescale 1ns/1ps
module tb_ssp_port;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdat = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ce = 1'b1;
    logic [7:0] v;
    wire [7:0] rdat;
    wire d_out, d_oe, c_out, c_oe, pend, tx_rdy, far_drv, slv_ck;
    wire link_ck = c_oe ? c_out : slv_ck;
    wire link_dat = d_oe ? d_out : far_drv;
    integer n_mismatch = 0;
    integer compares = 0;
    always #5 clk = ~clk;
    ssp_port i_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .addr_in(addr),
        .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
        .data_line_in(link_dat), .data_line_out(d_out), .data_line_oe_out(d_oe),
        .clock_line_in(link_ck), .clock_line_out(c_out), .clock_line_oe_out(c_oe),
        .rx_pending_out(pend), .tx_ready_out(tx_rdy));
    ssp_far_end i_far (.ck_in(link_ck), .dat_in(link_dat), .dut_oe_in(d_oe),
        .drv_out(far_drv), .slv_ck_out(slv_ck));
    task complete_run;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdat;
        chk({1'b0, v}, {1'b0, e});
    endtask
    task pend_is(input logic e);
        @(posedge clk);
        #1;
        chk({8'h00, pend}, {8'h00, e});
    endtask
    task wait_pend;
        integer i;
        for (i = 0; i < 3000 && pend !== 1'b1; i++)
            @(posedge clk);
        pend_is(1'b1);
    endtask
    task wait_edges(input integer n);
        integer i;
        for (i = 0; i < 3000 && i_far.n_edge < n; i++)
            @(posedge clk);
        repeat (100) @(posedge clk);
        chk(i_far.n_edge[8:0], n[8:0]);
    endtask
    task t_regs;
        rd_chk(3'h0, 8'h00);
        rd_chk(3'h1, 8'h00);
        rd_chk(3'h3, 8'h02);
        rd_chk(3'h4, 8'h00);
        rd_chk(3'h7, 8'h00);
        wr_reg(3'h1, 8'h5a);
        rd_chk(3'h1, 8'h5a);
        // A write while the clock enable is low must leave the register untouched.
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(3'h1, 8'h33);
        ce <= 1'b1;
        rd_chk(3'h1, 8'h5a);
        rd_chk(3'h2, 8'h00);
        // Shifter-empty bit must ignore the write while the ninth bit takes it.
        wr_reg(3'h3, 8'h01);
        rd_chk(3'h3, 8'h03);
        wr_reg(3'h3, 8'h00);
        rd_chk(3'h3, 8'h02);
    endtask
    task t_tx;
        i_far.start(36'h0);
        wr_reg(3'h1, 8'h00);
        wr_reg(3'h3, 8'hb4);
        wr_reg(3'h0, 8'h80);
        wr_reg(3'h2, 8'ha5);
        wr_reg(3'h2, 8'h3c);
        repeat (3) @(posedge clk);
        #1;
        chk({8'h00, tx_rdy}, 9'h000);
        wait_edges(16);
        chk({1'b0, i_far.rx_bits[7:0]}, 9'h0a5);
        chk({1'b0, i_far.rx_bits[15:8]}, 9'h03c);
        rd_chk(3'h3, 8'hb6);
    endtask
    task t_single;
        integer i;
        i_far.start({27'h0, 9'h096});
        // Transmit stays enabled so only the receive mode can release the data line.
        wr_reg(3'h3, 8'hb4);
        wr_reg(3'h0, 8'ha0);
        repeat (4) @(posedge clk);
        #1;
        chk({8'h00, d_oe}, 9'h000);
        wait_pend;
        wait_edges(8);
        rd_chk(3'h0, 8'h80);
        rd_chk(3'h4, 8'h96);
        pend_is(1'b0);
        // Clearing continuous receive after three bits must freeze the clock and drop them.
        i_far.start(36'h0);
        wr_reg(3'h0, 8'h90);
        for (i = 0; i < 300 && i_far.n_edge < 3; i++)
            @(posedge clk);
        wr_reg(3'h0, 8'h80);
        wait_edges(3);
        pend_is(1'b0);
    endtask
    task t_overrun;
        i_far.start({12'h0, 24'h332211});
        wr_reg(3'h0, 8'hb0);
        wait_edges(24);
        rd_chk(3'h0, 8'h92);
        wr_reg(3'h0, 8'h80);
        rd_chk(3'h0, 8'h80);
        rd_chk(3'h4, 8'h11);
        pend_is(1'b1);
        wr_reg(3'h0, 8'h00);
        repeat (3) @(posedge clk);
        pend_is(1'b0);
    endtask
    task t_slave9;
        i_far.start({27'h0, 9'h1c3});
        wr_reg(3'h3, 8'h10);
        wr_reg(3'h0, 8'hd0);
        i_far.clocks(9);
        wait_pend;
        chk({8'h00, c_oe}, 9'h000);
        rd_chk(3'h0, 8'hd1);
        rd_chk(3'h4, 8'hc3);
        wr_reg(3'h0, 8'h00);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_tx;
        t_single;
        t_overrun;
        t_slave9;
        complete_run;
    end
    // The scenarios need about a thousand cycles; twenty thousand leaves ample margin.
    initial
    begin
        #200000;
        n_mismatch++;
        complete_run;
    end
endmodule // tb_ssp_port

/* src/ssp_defines.vh */
// Register map, field positions, reset values and counts of the synchronous serial port.
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

`define SSP_ADDR_W 3
`define SSP_REG_RX_CTRL 3'h0
`define SSP_REG_DIVISOR 3'h1
`define SSP_REG_TX_DATA 3'h2
`define SSP_REG_TX_CTRL 3'h3
`define SSP_REG_RX_DATA 3'h4

`define SSP_RC_PORT_EN 7
`define SSP_RC_RX_NINE 6
`define SSP_RC_SINGLE 5
`define SSP_RC_CONT 4
`define SSP_RC_ADDR_MATCH 3
`define SSP_RC_FRAMING 2
`define SSP_RC_OVERRUN 1
`define SSP_RC_NINTH 0

`define SSP_TC_MASTER 7
`define SSP_TC_TX_NINE 6
`define SSP_TC_TX_EN 5
`define SSP_TC_SYNC 4
`define SSP_TC_HIGH_RATE 2
`define SSP_TC_EMPTY 1
`define SSP_TC_TX_NINTH 0

`define SSP_RX_CTRL_RESET 8'h00
`define SSP_TX_CTRL_RESET 8'h02
`define SSP_DIVISOR_RESET 8'h00
`define SSP_TX_DATA_RESET 8'h00

`define SSP_LAST_BIT_8 4'h7
`define SSP_LAST_BIT_9 4'h8
`define SSP_SCALE_HIGH 13'h0004
`define SSP_SCALE_LOW 13'h0010

`endif

/* src/ssp_port.v */
// Synchronous half-duplex serial port, master or slave, with its register file.
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_port (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire [`SSP_ADDR_W-1:0] addr_in,
    input wire [7:0] wr_data_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rd_data_out,
    input wire data_line_in,
    output reg data_line_out,
    output reg data_line_oe_out,
    input wire clock_line_in,
    output wire clock_line_out,
    output reg clock_line_oe_out,
    output wire rx_pending_out,
    output reg tx_ready_out
);
    reg rst_s1;
    reg rst_s2;
    wire rst_n;

    // Control fields.
    reg port_enable;
    reg rx_nine;
    reg single_rx;
    reg cont_rx;
    reg addr_match_en;
    reg clk_master;
    reg tx_nine;
    reg tx_enable;
    reg sync_mode;
    reg high_rate;
    reg tx_ninth;
    reg [7:0] rate_divisor;
    reg [7:0] tx_holding;

    // Engine state.
    reg hold_full;
    reg shifter_empty;
    reg [8:0] tx_shifter;
    reg tx_last_nine;
    reg [3:0] tx_cnt;
    reg [8:0] rx_shifter;
    reg [3:0] rx_cnt;
    reg overrun;
    reg overrun_cont;
    reg clk_reg;
    reg tx_bit;

    // Pin synchronisers.
    reg ck_m;
    reg ck_s;
    reg ck_d;
    reg dt_m;
    reg dt_s;

    wire tick;
    wire [8:0] fifo_head;
    wire fifo_full;
    wire fifo_valid;

    assign rst_n = rst_s2;
    assign clock_line_out = clk_reg;

    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ck_m <= 1'b0;
            ck_s <= 1'b0;
            ck_d <= 1'b0;
            dt_m <= 1'b0;
            dt_s <= 1'b0;
        end
        else if (ce_in)
        begin
            ck_m <= clock_line_in;
            ck_s <= ck_m;
            ck_d <= ck_s;
            dt_m <= data_line_in;
            dt_s <= dt_m;
        end
    end

    // Operating mode.
    wire port_on = port_enable & sync_mode;
    wire rx_mode = single_rx | cont_rx;
    wire tx_act = port_on & ~rx_mode & tx_enable & ~shifter_empty;
    wire rx_act = port_on & rx_mode & ~overrun;
    wire run = clk_master & (tx_act | rx_act);

    // Edges: as master from our own clock, as slave from the remote clock.
    wire lead = clk_master ? (tick & ~clk_reg) : (ck_s & ~ck_d);
    wire trail = clk_master ? (tick & clk_reg) : (~ck_s & ck_d);

    wire [3:0] tx_last = tx_last_nine ? `SSP_LAST_BIT_9 : `SSP_LAST_BIT_8;
    wire [3:0] rx_last = rx_nine ? `SSP_LAST_BIT_9 : `SSP_LAST_BIT_8;
    wire [8:0] next_rx_shifter = {dt_s, rx_shifter[8:1]};
    wire [8:0] rx_char = rx_nine ? next_rx_shifter : {1'b0, next_rx_shifter[8:1]};
    wire push = rx_act & trail & (rx_cnt == rx_last);

    wire wr_rx_ctrl = wr_in & (addr_in == `SSP_REG_RX_CTRL);
    wire wr_tx_data = wr_in & (addr_in == `SSP_REG_TX_DATA);
    wire wr_tx_ctrl = wr_in & (addr_in == `SSP_REG_TX_CTRL);
    wire rd_rx_data = rd_in & (addr_in == `SSP_REG_RX_DATA);
    wire pop = rd_rx_data & fifo_valid;

    wire load = port_on & shifter_empty & hold_full & tx_enable & ~rx_mode;
    wire next_hold_full = port_on & (wr_tx_data | (hold_full & ~load));

    ssp_rate_gen u_rate (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .run_in(run),
        .divisor_in(rate_divisor),
        .high_rate_in(high_rate),
        .tick_out(tick)
    );

    ssp_rx_fifo #(
        .WIDTH(9),
        .AW(1)
    ) u_fifo (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .flush_in(~port_on),
        .push_in(push),
        .wdata_in(rx_char),
        .pop_in(pop),
        .head_out(fifo_head),
        .full_out(fifo_full),
        .valid_out(rx_pending_out)
    );
    assign fifo_valid = rx_pending_out;

    // Register file.
    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_enable <= 1'b0;
            rx_nine <= 1'b0;
            single_rx <= 1'b0;
            cont_rx <= 1'b0;
            addr_match_en <= 1'b0;
            clk_master <= 1'b0;
            tx_nine <= 1'b0;
            tx_enable <= 1'b0;
            sync_mode <= 1'b0;
            high_rate <= 1'b0;
            tx_ninth <= 1'b0;
            rate_divisor <= `SSP_DIVISOR_RESET;
            tx_holding <= `SSP_TX_DATA_RESET;
        end
        else if (ce_in)
        begin
            if (wr_rx_ctrl)
            begin
                port_enable <= wr_data_in[`SSP_RC_PORT_EN];
                rx_nine <= wr_data_in[`SSP_RC_RX_NINE];
                single_rx <= wr_data_in[`SSP_RC_SINGLE];
                cont_rx <= wr_data_in[`SSP_RC_CONT];
                addr_match_en <= wr_data_in[`SSP_RC_ADDR_MATCH];
            end
            else if (push & clk_master)
            begin
                // A software write in the same cycle takes priority over the self-clear.
                single_rx <= 1'b0;
            end
            if (wr_tx_ctrl)
            begin
                clk_master <= wr_data_in[`SSP_TC_MASTER];
                tx_nine <= wr_data_in[`SSP_TC_TX_NINE];
                tx_enable <= wr_data_in[`SSP_TC_TX_EN];
                sync_mode <= wr_data_in[`SSP_TC_SYNC];
                high_rate <= wr_data_in[`SSP_TC_HIGH_RATE];
                tx_ninth <= wr_data_in[`SSP_TC_TX_NINTH];
            end
            if (wr_in & (addr_in == `SSP_REG_DIVISOR))
                rate_divisor <= wr_data_in;
            if (wr_tx_data)
                tx_holding <= wr_data_in;
        end
    end

    // Read data stands in the cycle after the read strobe.
    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_out <= 8'h00;
        else if (ce_in)
        begin
            if (!rd_in)
                rd_data_out <= 8'h00;
            else
            begin
                case (addr_in)
                    `SSP_REG_RX_CTRL:
                        rd_data_out <= {port_enable, rx_nine, single_rx, cont_rx,
                                        addr_match_en, 1'b0, overrun, fifo_head[8]};
                    `SSP_REG_DIVISOR:
                        rd_data_out <= rate_divisor;
                    `SSP_REG_TX_CTRL:
                        rd_data_out <= {clk_master, tx_nine, tx_enable, sync_mode,
                                        1'b0, high_rate, shifter_empty, tx_ninth};
                    `SSP_REG_RX_DATA:
                        rd_data_out <= fifo_head[7:0];
                    default:
                        rd_data_out <= 8'h00;
                endcase
            end
        end
    end

    // Master clock: low when idle, toggles every half period while running.
    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            clk_reg <= 1'b0;
        else if (ce_in)
        begin
            if (!run)
                clk_reg <= 1'b0;
            else if (tick)
                clk_reg <= ~clk_reg;
        end
    end

    // Transmit engine.
    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_full <= 1'b0;
            tx_ready_out <= 1'b1;
            shifter_empty <= 1'b1;
            tx_shifter <= 9'h000;
            tx_last_nine <= 1'b0;
            tx_cnt <= 4'h0;
            tx_bit <= 1'b0;
        end
        else if (ce_in)
        begin
            hold_full <= next_hold_full;
            tx_ready_out <= ~next_hold_full;
            if (!port_on)
            begin
                shifter_empty <= 1'b1;
                tx_cnt <= 4'h0;
            end
            else if (load)
            begin
                tx_shifter <= {tx_nine & tx_ninth, tx_holding};
                tx_last_nine <= tx_nine;
                shifter_empty <= 1'b0;
                tx_cnt <= 4'h0;
            end
            else if (tx_act)
            begin
                if (lead)
                begin
                    tx_bit <= tx_shifter[0];
                    tx_shifter <= {1'b0, tx_shifter[8:1]};
                end
                if (trail)
                begin
                    if (tx_cnt == tx_last)
                    begin
                        tx_cnt <= 4'h0;
                        shifter_empty <= 1'b1;
                    end
                    else
                        tx_cnt <= tx_cnt + 4'h1;
                end
            end
        end
    end

    // Receive engine and overrun tracking.
    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_shifter <= 9'h000;
            rx_cnt <= 4'h0;
            overrun <= 1'b0;
            overrun_cont <= 1'b0;
        end
        else if (ce_in)
        begin
            if (!rx_act)
                rx_cnt <= 4'h0;
            else if (trail)
            begin
                rx_shifter <= next_rx_shifter;
                if (rx_cnt == rx_last)
                    rx_cnt <= 4'h0;
                else
                    rx_cnt <= rx_cnt + 4'h1;
            end
            if (!port_on)
                overrun <= 1'b0;
            else if (push & fifo_full)
            begin
                overrun <= 1'b1;
                overrun_cont <= cont_rx;
            end
            else if (overrun & ~overrun_cont & rd_rx_data)
                overrun <= 1'b0;
            else if (overrun & overrun_cont & ~cont_rx)
                overrun <= 1'b0;
        end
    end

    // Pin drivers.
    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_line_out <= 1'b0;
            data_line_oe_out <= 1'b0;
            clock_line_oe_out <= 1'b0;
        end
        else if (ce_in)
        begin
            data_line_out <= tx_bit;
            data_line_oe_out <= port_on & ~rx_mode & tx_enable;
            clock_line_oe_out <= port_on & clk_master;
        end
    end
endmodule // ssp_port

/* src/ssp_rate_gen.v */
// Half-period tick generator for the master bit clock.
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_rate_gen (
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire run_in,
    input wire [7:0] divisor_in,
    input wire high_rate_in,
    output reg tick_out
);
    reg [12:0] count;
    wire [12:0] scale;
    wire [25:0] product;
    wire [12:0] span;

    assign scale = high_rate_in ? `SSP_SCALE_HIGH : `SSP_SCALE_LOW;
    assign product = ({5'h00, divisor_in} + 13'h0001) * scale;
    assign span = product[12:0];

    // Counter restarts whenever the clock is idle so every character begins with a full half.
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count <= 13'h0000;
            tick_out <= 1'b0;
        end
        else if (ce_in)
        begin
            if (!run_in)
            begin
                count <= 13'h0000;
                tick_out <= 1'b0;
            end
            else if (count == span - 13'h0001)
            begin
                count <= 13'h0000;
                tick_out <= 1'b1;
            end
            else
            begin
                count <= count + 13'h0001;
                tick_out <= 1'b0;
            end
        end
    end
endmodule // ssp_rate_gen

/* src/ssp_rx_fifo.v */
// Small receive FIFO held in flip-flops, two entries by default.
`timescale 1ns/1ps
module ssp_rx_fifo #(
    parameter WIDTH = 9,
    parameter AW = 1
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire flush_in,
    input wire push_in,
    input wire [WIDTH-1:0] wdata_in,
    input wire pop_in,
    output wire [WIDTH-1:0] head_out,
    output wire full_out,
    output reg valid_out
);
    localparam DEPTH = 1 << AW;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_push;
    wire do_pop;
    wire [AW:0] next_count;

    assign full_out = (count == DEPTH[AW:0]);
    assign do_push = push_in & ~full_out;
    assign do_pop = pop_in & valid_out;
    assign next_count = count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    assign head_out = mem[rd_ptr];

    integer i;
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            valid_out <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
        end
        else if (ce_in)
        begin
            if (flush_in)
            begin
                wr_ptr <= {AW{1'b0}};
                rd_ptr <= {AW{1'b0}};
                count <= {(AW+1){1'b0}};
                valid_out <= 1'b0;
            end
            else
            begin
                if (do_push)
                begin
                    mem[wr_ptr] <= wdata_in;
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (do_pop)
                    rd_ptr <= rd_ptr + 1'b1;
                count <= next_count;
                valid_out <= (next_count != {(AW+1){1'b0}});
            end
        end
    end
endmodule // ssp_rx_fifo
